// File: fbd_regs.svh
`ifndef FBD_REGS_SVH
`define FBD_REGS_SVH

// Clock period of clk_sys in ns
`define FBD_CLK_NS 4
// Bus cycle timing in ns, with cycle counts rounded up
`define FBD_T_SETUP_NS 10
`define FBD_T_STROBE_NS 70
`define FBD_T_HOLD_NS 10
`define FBD_T_RESET_NS 500
`define FBD_T_RECOV_NS 50
`define FBD_SETUP_CYC ((`FBD_T_SETUP_NS + `FBD_CLK_NS - 1) / `FBD_CLK_NS)
`define FBD_STROBE_CYC ((`FBD_T_STROBE_NS + `FBD_CLK_NS - 1) / `FBD_CLK_NS)
`define FBD_HOLD_CYC ((`FBD_T_HOLD_NS + `FBD_CLK_NS - 1) / `FBD_CLK_NS)
`define FBD_RESET_CYC ((`FBD_T_RESET_NS + `FBD_CLK_NS - 1) / `FBD_CLK_NS)
`define FBD_RECOV_CYC ((`FBD_T_RECOV_NS + `FBD_CLK_NS - 1) / `FBD_CLK_NS)

// First write cycle of the two-cycle program; arbitrary default values
`define FBD_FAST_ADDR 21'h000000
`define FBD_FAST_CODE 16'h00a0

// Address bits forced during sector protect and unprotect
`define FBD_PROT_SEL_BIT 6
`define FBD_PROT_A1_BIT 1
`define FBD_PROT_A0_BIT 0

// Data line that carries the lowest byte address in byte mode
`define FBD_BYTE_ADDR_LINE 15

`endif

// File: fbd_pkg.sv
package fbd_pkg;

	// Host operations on the flash bus
	typedef enum logic [2:0] {
		FBD_OP_READ = 3'h0,
		FBD_OP_WRITE = 3'h1,
		FBD_OP_PROG2 = 3'h2,
		FBD_OP_PROTECT = 3'h3,
		FBD_OP_UNPROT = 3'h4,
		FBD_OP_CLEAR = 3'h5
	} fbd_op_t;

	// Bus cycle phases, one-hot
	typedef enum logic [5:0] {
		FBD_ST_IDLE = 6'h01,
		FBD_ST_SETUP = 6'h02,
		FBD_ST_STROBE = 6'h04,
		FBD_ST_HOLD = 6'h08,
		FBD_ST_RESET = 6'h10,
		FBD_ST_RECOV = 6'h20
	} fbd_state_t;

endpackage

// File: fbd_pin_encode.sv
`timescale 1ns/10ps
`default_nettype none

module fbd_pin_encode (
	// Cycle phase and operation
	input wire fbd_pkg::fbd_state_t state,
	input wire fbd_pkg::fbd_op_t op,
	// Control pin levels to present next
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic reset_n,
	output logic id_level
);

	logic is_prot;
	logic is_read;

	assign is_prot = (op == fbd_pkg::FBD_OP_PROTECT) || (op == fbd_pkg::FBD_OP_UNPROT);
	assign is_read = (op == fbd_pkg::FBD_OP_READ);

	// Control levels per phase
	always_comb begin
		ce_n = 1'b1;
		oe_n = 1'b1;
		we_n = 1'b1;
		reset_n = 1'b1;
		id_level = 1'b0;
		case (state)
			fbd_pkg::FBD_ST_SETUP, fbd_pkg::FBD_ST_HOLD: begin
				ce_n = 1'b0;
				id_level = is_prot;
			end
			fbd_pkg::FBD_ST_STROBE: begin
				ce_n = 1'b0;
				oe_n = !is_read;
				we_n = is_read;
				id_level = is_prot;
			end
			fbd_pkg::FBD_ST_RESET: begin
				reset_n = 1'b0;
			end
			default: begin
				ce_n = 1'b1;
			end
		endcase
	end

endmodule

`default_nettype wire

// File: fbd_host.sv
// Overview of operation
// - Read: chip select, output enable low
// - Write: chip select, write enable low
// - Fast program takes two write cycles
// - Protect: write strobe at ID level, A6 low
// - Unprotect: same levels with A6 high
`timescale 1ns/10ps
`default_nettype none
`include "fbd_regs.svh"

module fbd_host (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// User command port
	input wire logic cmd_valid,
	input wire fbd_pkg::fbd_op_t cmd_op,
	input wire logic [21:0] cmd_addr,
	input wire logic [15:0] cmd_wdata,
	input wire logic cmd_byte_mode,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic [15:0] rsp_rdata,
	// Protect and accelerate controls
	input wire logic accel_req,
	input wire logic wp_high_req,
	output logic protect_accel_pin,
	output logic accel_level_en,
	// Flash control pins
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic flash_reset_n,
	output logic flash_id_level,
	output logic flash_byte_n,
	output logic [20:0] flash_addr,
	input wire logic ready_busy_n,
	// Flash data lines
	input wire logic [15:0] data_lines_in,
	output logic [15:0] data_lines_out,
	output logic [15:0] data_lines_oe
);

	fbd_pkg::fbd_state_t state_reg, state_next;
	fbd_pkg::fbd_op_t op_reg, op_next;
	logic [7:0] count_reg, count_next;
	logic [21:0] addr_reg, addr_next;
	logic [15:0] wdata_reg, wdata_next;
	logic byte_reg, byte_next;
	logic first_reg, first_next;
	logic [15:0] rdata_reg, rdata_next;
	logic rsp_reg, rsp_next;
	logic ready_reg, ready_next;
	logic ce_n_reg, oe_n_reg, we_n_reg, rst_n_reg, id_reg;
	logic ce_n_nx, oe_n_nx, we_n_nx, rst_n_nx, id_nx;
	logic byte_n_reg;
	logic [20:0] fa_reg, fa_next;
	logic [15:0] dout_reg, dout_next, doe_reg, doe_next;
	logic wp_reg, acc_reg;

	// True when the phase counter reaches its last cycle
	function automatic logic fbd_last(input logic [7:0] cnt, input logic [7:0] len);
		fbd_last = (cnt == (len - 8'h01));
	endfunction

	// Sequencer of the bus cycle phases
	always_comb begin
		state_next = state_reg;
		op_next = op_reg;
		count_next = count_reg + 8'h01;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		byte_next = byte_reg;
		first_next = first_reg;
		rdata_next = rdata_reg;
		rsp_next = 1'b0;
		ready_next = 1'b0;
		case (state_reg)
			fbd_pkg::FBD_ST_IDLE: begin
				count_next = 8'h00;
				ready_next = 1'b1;
				if (cmd_valid && ready_reg) begin
					op_next = cmd_op;
					addr_next = cmd_addr;
					wdata_next = cmd_wdata;
					byte_next = cmd_byte_mode;
					first_next = (cmd_op == fbd_pkg::FBD_OP_PROG2);
					ready_next = 1'b0;
					if (cmd_op == fbd_pkg::FBD_OP_CLEAR) begin
						state_next = fbd_pkg::FBD_ST_RESET;
					end else begin
						state_next = fbd_pkg::FBD_ST_SETUP;
					end
				end
			end
			fbd_pkg::FBD_ST_SETUP: begin
				if (fbd_last(count_reg, 8'(`FBD_SETUP_CYC))) begin
					state_next = fbd_pkg::FBD_ST_STROBE;
					count_next = 8'h00;
				end
			end
			fbd_pkg::FBD_ST_STROBE: begin
				if (fbd_last(count_reg, 8'(`FBD_STROBE_CYC))) begin
					state_next = fbd_pkg::FBD_ST_HOLD;
					count_next = 8'h00;
					if (op_reg == fbd_pkg::FBD_OP_READ) begin
						rdata_next = data_lines_in;
						if (byte_reg) begin
							rdata_next = {8'h00, data_lines_in[7:0]};
						end
					end
				end
			end
			fbd_pkg::FBD_ST_HOLD: begin
				if (fbd_last(count_reg, 8'(`FBD_HOLD_CYC))) begin
					count_next = 8'h00;
					if (first_reg) begin
						first_next = 1'b0;
						state_next = fbd_pkg::FBD_ST_SETUP;
					end else begin
						state_next = fbd_pkg::FBD_ST_IDLE;
						rsp_next = 1'b1;
					end
				end
			end
			fbd_pkg::FBD_ST_RESET: begin
				if (fbd_last(count_reg, 8'(`FBD_RESET_CYC))) begin
					state_next = fbd_pkg::FBD_ST_RECOV;
					count_next = 8'h00;
				end
			end
			fbd_pkg::FBD_ST_RECOV: begin
				if (fbd_last(count_reg, 8'(`FBD_RECOV_CYC))) begin
					state_next = fbd_pkg::FBD_ST_IDLE;
					count_next = 8'h00;
					rsp_next = 1'b1;
				end
			end
			default: begin
				state_next = fbd_pkg::FBD_ST_IDLE;
			end
		endcase
	end

	// Control pin levels for the next phase
	fbd_pin_encode u_enc (
		.state(state_next),
		.op(op_next),
		.ce_n(ce_n_nx),
		.oe_n(oe_n_nx),
		.we_n(we_n_nx),
		.reset_n(rst_n_nx),
		.id_level(id_nx)
	);

	// Address and data lines for the next phase
	always_comb begin
		fa_next = addr_next[21:1];
		dout_next = wdata_next;
		doe_next = 16'h0000;
		if (first_next) begin
			fa_next = `FBD_FAST_ADDR;
			dout_next = `FBD_FAST_CODE;
		end
		if (op_next == fbd_pkg::FBD_OP_PROTECT || op_next == fbd_pkg::FBD_OP_UNPROT) begin
			fa_next[`FBD_PROT_SEL_BIT] = (op_next == fbd_pkg::FBD_OP_UNPROT);
			fa_next[`FBD_PROT_A1_BIT] = 1'b1;
			fa_next[`FBD_PROT_A0_BIT] = 1'b0;
		end
		// Drive data only while output enable is high, except line 15, which carries the byte address in byte mode during reads too
		if (state_next != fbd_pkg::FBD_ST_IDLE && state_next != fbd_pkg::FBD_ST_RESET &&
			state_next != fbd_pkg::FBD_ST_RECOV && op_next != fbd_pkg::FBD_OP_READ) begin
			doe_next = byte_next ? 16'h00ff : 16'hffff;
		end
		if (byte_next) begin
			dout_next[14:8] = 7'h00;
			dout_next[`FBD_BYTE_ADDR_LINE] = addr_next[0];
			if (state_next != fbd_pkg::FBD_ST_RESET && state_next != fbd_pkg::FBD_ST_RECOV) begin
				doe_next[`FBD_BYTE_ADDR_LINE] = 1'b1;
			end
		end
	end

	// Registers; pins except protect_accel_pin and accel_level_en change only at phase boundaries so address holds across edges
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg <= fbd_pkg::FBD_ST_IDLE;
			op_reg <= fbd_pkg::FBD_OP_READ;
			count_reg <= 8'h00;
			addr_reg <= 22'h000000;
			wdata_reg <= 16'h0000;
			byte_reg <= 1'b0;
			first_reg <= 1'b0;
			rdata_reg <= 16'h0000;
			rsp_reg <= 1'b0;
			ready_reg <= 1'b0;
			ce_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			rst_n_reg <= 1'b1;
			id_reg <= 1'b0;
			byte_n_reg <= 1'b1;
			fa_reg <= 21'h000000;
			dout_reg <= 16'h0000;
			doe_reg <= 16'h0000;
			wp_reg <= 1'b0;
			acc_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			op_reg <= op_next;
			count_reg <= count_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			byte_reg <= byte_next;
			first_reg <= first_next;
			rdata_reg <= rdata_next;
			rsp_reg <= rsp_next;
			ready_reg <= ready_next;
			ce_n_reg <= ce_n_nx;
			oe_n_reg <= oe_n_nx;
			we_n_reg <= we_n_nx;
			rst_n_reg <= rst_n_nx;
			id_reg <= id_nx;
			byte_n_reg <= !byte_next;
			fa_reg <= fa_next;
			dout_reg <= dout_next;
			doe_reg <= doe_next;
			wp_reg <= wp_high_req || accel_req;
			acc_reg <= accel_req;
		end
	end

	// Outputs straight from flip-flops
	assign cmd_ready = ready_reg;
	assign rsp_valid = rsp_reg;
	assign rsp_rdata = rdata_reg;
	assign protect_accel_pin = wp_reg;
	assign accel_level_en = acc_reg;
	assign flash_ce_n = ce_n_reg;
	assign flash_oe_n = oe_n_reg;
	assign flash_we_n = we_n_reg;
	assign flash_reset_n = rst_n_reg;
	assign flash_id_level = id_reg;
	assign flash_byte_n = byte_n_reg;
	assign flash_addr = fa_reg;
	assign data_lines_out = dout_reg;
	assign data_lines_oe = doe_reg;

	// Checks on the pin sequencing
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);

	read_levels_a: assert property (!flash_oe_n |-> !flash_ce_n && flash_we_n && flash_reset_n)
		else $error("read strobe with wrong control levels");
	write_levels_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
		else $error("write strobe with wrong control levels");
	data_drive_a: assert property ((data_lines_oe[7:0] != 8'h00) |-> flash_oe_n)
		else $error("data lines driven while output enabled");
	byte_float_a: assert property (!flash_byte_n |-> data_lines_oe[14:8] == 7'h00)
		else $error("upper lines driven in byte mode");
	protect_addr_a: assert property (flash_id_level && !flash_we_n |->
		flash_addr[1] && !flash_addr[0] && flash_reset_n)
		else $error("protect address pattern wrong");
	latch_hold_a: assert property ($rose(flash_we_n) |-> $stable(flash_addr) &&
		$stable(data_lines_out))
		else $error("address or data moved at write edge");
	clear_pulse_a: assert property ($fell(flash_reset_n) |-> !flash_reset_n [*8])
		else $error("clear pulse too short");
	fast_second_a: assert property ($fell(first_reg) |-> ##1 (state_reg == fbd_pkg::FBD_ST_SETUP)
		##[1:40] !flash_we_n)
		else $error("second program cycle missing");
	strobe_width_a: assert property ($fell(flash_we_n) |-> !flash_we_n [*8])
		else $error("write strobe too short");

	read_done_c: cover property (rsp_valid && op_reg == fbd_pkg::FBD_OP_READ);
	prog2_done_c: cover property (rsp_valid && op_reg == fbd_pkg::FBD_OP_PROG2);
	unprot_c: cover property (!flash_we_n && flash_id_level && flash_addr[6]);
	clear_done_c: cover property (rsp_valid && op_reg == fbd_pkg::FBD_OP_CLEAR);

endmodule

`default_nettype wire

// File: fbd_dummy_unused.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: fbd_flash_model.sv
`timescale 1ns/10ps
`default_nettype none

module fbd_flash_model #(
	parameter int ACC_NS = 60,
	parameter logic [15:0] ID_CODE = 16'h0c3e // Arbitrary identification code
) (
	// Control pins
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic reset_n,
	input wire logic id_level,
	input wire logic byte_n,
	input wire logic wp_pin,
	input wire logic accel,
	// Address and data
	input wire logic [20:0] addr,
	input wire logic [15:0] host_q,
	input wire logic [15:0] host_oe,
	output logic [15:0] dq
);
	logic [15:0] mem [logic [20:0]];
	bit prot [logic [8:0]];
	logic armed = 1'b0;
	logic idm = 1'b0;
	logic [15:0] arr_w;
	logic [15:0] old_w;
	logic [15:0] last_q = 16'h5a5a;
	logic [15:0] dev_q;
	logic [15:0] dev_d;
	wire rd = !ce_n && !oe_n && we_n && reset_n;

	function automatic logic [15:0] rdw(input logic [20:0] a);
		return mem.exists(a) ? mem[a] : 16'hffff;
	endfunction

	function automatic bit locked(input logic [8:0] s);
		return !accel && ((!wp_pin && s >= 9'h1fe) || (prot.exists(s) && prot[s]));
	endfunction

	// Array read, same access time in every bank; released lines show the inverse
	always @(addr, rd, host_q, byte_n, last_q, idm) begin
		arr_w = idm ? ID_CODE : rdw(addr);
		dev_q = ~last_q;
		if (rd && byte_n)
			dev_q = arr_w;
		else if (rd)
			dev_q[7:0] = host_q[15] ? arr_w[15:8] : arr_w[7:0];
	end
	assign #(ACC_NS) dev_d = dev_q;
	assign dq = (host_oe & host_q) | (~host_oe & dev_d);
	always @(negedge rd) last_q = dev_d;

	// Command latch, taken as the write strobe rises
	always @(posedge we_n) begin
		old_w = rdw(addr);
		if (!ce_n && oe_n && (reset_n || id_level)) begin
			if (id_level)
				prot[addr[20:12]] = !addr[6];
			else if (armed) begin
				armed = 1'b0;
				if (!locked(addr[20:12]) && byte_n)
					mem[addr] = host_q;
				else if (!locked(addr[20:12]))
					mem[addr] = host_q[15] ? {host_q[7:0], old_w[7:0]} :
						{old_w[15:8], host_q[7:0]};
			end else begin
				armed = (addr == 21'h0 && host_q[7:0] == 8'ha0);
				idm = idm || (host_q[7:0] == 8'h90);
			end
		end
	end

	// Clear pulse drops the fast program and ID readout states
	always @(negedge reset_n) begin
		if (!id_level) begin
			armed = 1'b0;
			idm = 1'b0;
		end
	end

endmodule

`default_nettype wire

// File: fbd_host_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "fbd_regs.svh"

module fbd_host_tb;
	localparam int CYC_OP = `FBD_SETUP_CYC + `FBD_STROBE_CYC + `FBD_HOLD_CYC;
	localparam int CYC_CLR = `FBD_RESET_CYC + `FBD_RECOV_CYC;
	localparam logic [15:0] ID_CODE = 16'h0c3e; // Arbitrary identification code
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic cmd_valid = 1'b0;
	fbd_pkg::fbd_op_t cmd_op = fbd_pkg::FBD_OP_READ;
	logic [21:0] cmd_addr = 22'h0;
	logic [15:0] cmd_wdata = 16'h0;
	logic cmd_byte_mode = 1'b0;
	logic accel_req = 1'b0;
	logic wp_high_req = 1'b0;
	logic rb_n = 1'b1;
	logic cmd_ready, rsp_valid, pa_pin, acc_en, ce_n, oe_n, we_n, rst_n, id_lv, byte_n;
	logic [15:0] rsp_rdata, dq, dq_out, dq_oe;
	logic [20:0] f_addr;
	logic [21:0] ra;
	int n_fail = 0;
	int checks = 0;
	logic [31:0] seed = 32'd84050;
	logic [15:0] exp_mem [int];
	bit exp_prot [int];
	bit armed = 0;
	bit idm = 0;

	// Clock
	always #2 clk_sys = ~clk_sys;

	fbd_host dut (.clk_sys(clk_sys), .srst(srst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_byte_mode(cmd_byte_mode),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
		.accel_req(accel_req), .wp_high_req(wp_high_req), .protect_accel_pin(pa_pin),
		.accel_level_en(acc_en), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.flash_reset_n(rst_n), .flash_id_level(id_lv), .flash_byte_n(byte_n),
		.flash_addr(f_addr), .ready_busy_n(rb_n), .data_lines_in(dq),
		.data_lines_out(dq_out), .data_lines_oe(dq_oe));

	fbd_flash_model #(.ID_CODE(ID_CODE)) flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(rst_n),
		.id_level(id_lv), .byte_n(byte_n), .wp_pin(pa_pin), .accel(acc_en), .addr(f_addr),
		.host_q(dq_out), .host_oe(dq_oe), .dq(dq));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [15:0] rd_word(input int wa);
		return exp_mem.exists(wa) ? exp_mem[wa] : 16'hffff;
	endfunction

	// Reference write: arm on the fast code, program on the next write
	function automatic void mdl_write(input logic [21:0] a, input logic [15:0] d, input bit bm);
		int wa = a[21:1];
		int s = a[21:13];
		logic [15:0] w = rd_word(wa);
		bit lock = !accel_req && ((!wp_high_req && s >= 'h1fe) || (exp_prot.exists(s) && exp_prot[s]));
		if (!armed) begin
			armed = (wa == 0 && d[7:0] == 8'ha0);
			idm = idm || (d[7:0] == 8'h90);
		end else begin
			armed = 0;
			if (!lock)
				exp_mem[wa] = !bm ? d : a[0] ? {d[7:0], w[7:0]} : {w[15:8], d[7:0]};
		end
	endfunction

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One host operation with pin, latency and result checks
	task automatic op(input fbd_pkg::fbd_op_t o, input logic [21:0] a, input logic [15:0] d,
		input bit bm);
		int n = 0;
		bit rdop = (o == fbd_pkg::FBD_OP_READ);
		bit clr = (o == fbd_pkg::FBD_OP_CLEAR);
		bit wr = !rdop && !clr;
		bit pr = o inside {fbd_pkg::FBD_OP_PROTECT, fbd_pkg::FBD_OP_UNPROT};
		logic [4:0] ep = rdop ? 5'h06 : wr ? {4'h5, pr} : 5'h00;
		logic [4:0] mk = clr ? 5'h03 : 5'h1f;
		logic [15:0] eo = wr ? (bm ? 16'h80ff : 16'hffff) : (rdop && bm) ? 16'h8000 : 16'h0;
		logic [15:0] w = idm ? ID_CODE : rd_word(a[21:1]);
		@(negedge clk_sys);
		while (cmd_ready !== 1'b1) @(negedge clk_sys);
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_addr = a;
		cmd_wdata = d;
		cmd_byte_mode = bm;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 300) begin
			if (n == 10) begin
				chk("pins", ep & mk, {ce_n, oe_n, we_n, rst_n, id_lv} & mk);
				chk("data_oe", eo, dq_oe);
				if (pr) chk("prot_addr", {o == fbd_pkg::FBD_OP_UNPROT, 2'h2}, {f_addr[6], f_addr[1:0]});
				if (!pr && !clr) chk("byte_n", !bm, byte_n);
			end
			@(negedge clk_sys);
			n++;
		end
		chk("latency", o == fbd_pkg::FBD_OP_PROG2 ? 2 * CYC_OP : clr ? CYC_CLR : CYC_OP, n);
		if (rdop)
			chk("rdata", bm ? {8'h0, a[0] ? w[15:8] : w[7:0]} : w, rsp_rdata);
		else if (clr) begin
			armed = 0;
			idm = 0;
		end
		else if (pr)
			exp_prot[a[21:13]] = (o == fbd_pkg::FBD_OP_PROTECT);
		else if (o == fbd_pkg::FBD_OP_WRITE)
			mdl_write(a, d, bm);
		else begin
			mdl_write(22'h0, 16'h00a0, bm);
			mdl_write(a, d, bm);
		end
	endtask

	task automatic report_and_stop();
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		repeat (12) @(negedge clk_sys);
		srst = 1'b0;
		op(fbd_pkg::FBD_OP_READ, 22'h1234, 16'h0, 1'b0);
		for (int i = 0; i < 24; i++) begin
			ra = rnd();
			op(fbd_pkg::FBD_OP_PROG2, ra, rnd(), ra[1]);
			op(fbd_pkg::FBD_OP_READ, ra, 16'h0, ra[2]);
			op(fbd_pkg::FBD_OP_WRITE, ra, rnd(), ra[3]);
			op(fbd_pkg::FBD_OP_READ, ra ^ 22'h1, 16'h0, ra[4]);
		end
		for (int k = 0; k < 4; k++) begin
			accel_req = k[1];
			op(k[0] ? fbd_pkg::FBD_OP_UNPROT : fbd_pkg::FBD_OP_PROTECT, 22'h0a4000, 16'h0, 1'b0);
			op(fbd_pkg::FBD_OP_PROG2, 22'h0a4010, rnd(), 1'b0);
			op(fbd_pkg::FBD_OP_READ, 22'h0a4010, 16'h0, 1'b0);
		end
		accel_req = 1'b0;
		for (int k = 0; k < 2; k++) begin
			wp_high_req = k[0];
			op(fbd_pkg::FBD_OP_PROG2, 22'h3fc000, rnd(), 1'b0);
			op(fbd_pkg::FBD_OP_READ, 22'h3fc000, 16'h0, 1'b0);
		end
		op(fbd_pkg::FBD_OP_WRITE, 22'h0, 16'h0090, 1'b0);
		op(fbd_pkg::FBD_OP_READ, 22'h000a02, 16'h0, 1'b0);
		op(fbd_pkg::FBD_OP_WRITE, 22'h0, 16'h00a0, 1'b0);
		op(fbd_pkg::FBD_OP_CLEAR, 22'h0, 16'h0, 1'b0);
		op(fbd_pkg::FBD_OP_WRITE, 22'h000200, 16'h1234, 1'b0);
		op(fbd_pkg::FBD_OP_READ, 22'h000200, 16'h0, 1'b0);
		report_and_stop();
	end

endmodule

`default_nettype wire
